// File: hw/sal_regs.vh
// Register map, field layout, reset values and timing constants of the limiter block
`ifndef SAL_REGS_VH
`define SAL_REGS_VH

`define SAL_ADDR_LEFT_RATES      8'h0e
`define SAL_ADDR_LEFT_THR_SLOPE  8'h0f
`define SAL_ADDR_LEFT_KNEE       8'h10
`define SAL_ADDR_RIGHT_RATES     8'h11
`define SAL_ADDR_RIGHT_THR_SLOPE 8'h12
`define SAL_ADDR_RIGHT_KNEE      8'h13

`define SAL_RST_LEFT_RATES       8'ha0
`define SAL_RST_THR_SLOPE        8'h51
`define SAL_RST_KNEE             8'h22
`define SAL_RST_RIGHT_RATES      8'ha8

`define SAL_MASK_LEFT_RATES      8'hf7
`define SAL_MASK_RIGHT_RATES     8'hff
`define SAL_MASK_THR_SLOPE       8'hfb

`define SAL_RECOVERY_MSB         7
`define SAL_RECOVERY_LSB         6
`define SAL_ATTACK_MSB           5
`define SAL_ATTACK_LSB           4
`define SAL_LINK_BIT             3
`define SAL_TRACK_BIT            2
`define SAL_MODE_MSB             1
`define SAL_MODE_LSB             0
`define SAL_THR_MSB              7
`define SAL_THR_LSB              3
`define SAL_SLOPE_MSB            1
`define SAL_SLOPE_LSB            0

`define SAL_MODE_OFF             2'h0
`define SAL_MODE_ON              2'h1
`define SAL_MODE_MUTE_LOW        2'h2
`define SAL_MODE_ON_LOW          2'h3

`define SAL_CLK_MHZ              250
`define SAL_ATTACK_US_0          120
`define SAL_ATTACK_US_1          60
`define SAL_ATTACK_US_2          30
`define SAL_ATTACK_US_3          20
`define SAL_RELEASE_MS_0         3200
`define SAL_RELEASE_MS_1         1600
`define SAL_RELEASE_MS_2         1200
`define SAL_RELEASE_MS_3         800
`define SAL_ATTACK_CYC(us)       ((us) * `SAL_CLK_MHZ)
`define SAL_RELEASE_CYC(ms)      ((ms) * `SAL_CLK_MHZ * 1000)

`endif

// File: hw/sal_gain_core.v
// One limiter gain engine: attenuation in 1 dB steps paced by attack and release timers
`include "sal_regs.vh"

module sal_gain_core #(
  parameter integer DATA_W  = 24,
  parameter integer ATT_MAX = 48,
  parameter [31:0]  ATK0    = `SAL_ATTACK_CYC(`SAL_ATTACK_US_0),
  parameter [31:0]  ATK1    = `SAL_ATTACK_CYC(`SAL_ATTACK_US_1),
  parameter [31:0]  ATK2    = `SAL_ATTACK_CYC(`SAL_ATTACK_US_2),
  parameter [31:0]  ATK3    = `SAL_ATTACK_CYC(`SAL_ATTACK_US_3),
  parameter [31:0]  REL0    = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_0),
  parameter [31:0]  REL1    = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_1),
  parameter [31:0]  REL2    = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_2),
  parameter [31:0]  REL3    = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_3)
) (
  input  wire              clock_i,
  input  wire              reset_n_i,
  input  wire              active_i,
  input  wire [DATA_W-2:0] peak_i,
  input  wire [DATA_W-2:0] threshold_i,
  input  wire [1:0]        attack_code_i,
  input  wire [1:0]        recovery_code_i,
  output reg  [15:0]       gain_o,
  output wire [5:0]        atten_db_o
);
  reg  [5:0]        att_reg;
  reg  [31:0]       timer_reg;
  reg               dir_up_reg;
  reg  [31:0]       atk_period;
  reg  [31:0]       rel_period;
  reg  [15:0]       frac_gain;
  reg  [3:0]        octave;
  reg  [2:0]        rem_db;
  wire [5:0]        oct_full = att_reg / 6'd6;
  wire [5:0]        rem_full = att_reg % 6'd6;
  wire [DATA_W+14:0] scaled_full;
  wire [DATA_W-2:0] scaled_peak;
  wire              over;

  assign atten_db_o = att_reg;

  always @* begin
    case (attack_code_i)
      2'h0:    atk_period = ATK0;
      2'h1:    atk_period = ATK1;
      2'h2:    atk_period = ATK2;
      default: atk_period = ATK3;
    endcase
    case (recovery_code_i)
      2'h0:    rel_period = REL0;
      2'h1:    rel_period = REL1;
      2'h2:    rel_period = REL2;
      default: rel_period = REL3;
    endcase
  end

  // 1 dB steps: six steps are close to one halving
  always @* begin
    octave = oct_full[3:0];
    rem_db = rem_full[2:0];
    case (rem_db)
      3'h0:    frac_gain = 16'h7fff;
      3'h1:    frac_gain = 16'h7215;
      3'h2:    frac_gain = 16'h65ad;
      3'h3:    frac_gain = 16'h5a9e;
      3'h4:    frac_gain = 16'h50c3;
      default: frac_gain = 16'h47fb;
    endcase
    gain_o = frac_gain >> octave;
  end

  assign scaled_full = peak_i * gain_o;
  assign scaled_peak = scaled_full[DATA_W+13:15];
  assign over        = scaled_peak > threshold_i;

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      att_reg    <= 6'h00;
      timer_reg  <= 32'h0;
      dir_up_reg <= 1'b0;
    end else if (!active_i) begin
      att_reg    <= 6'h00;
      timer_reg  <= 32'h0;
      dir_up_reg <= 1'b0;
    end else if (over != dir_up_reg) begin
      dir_up_reg <= over;
      timer_reg  <= 32'h0;
    end else if (over) begin
      if (timer_reg >= atk_period - 32'h1) begin // [RULE5]
        timer_reg <= 32'h0;
        if ({26'h0, att_reg} < ATT_MAX)
          att_reg <= att_reg + 6'h01;
      end else begin
        timer_reg <= timer_reg + 32'h1;
      end
    end else if (att_reg != 6'h00) begin
      if (timer_reg >= rel_period - 32'h1) begin // [RULE4]
        timer_reg <= 32'h0;
        att_reg   <= att_reg - 6'h01;
      end else begin
        timer_reg <= timer_reg + 32'h1;
      end
    end else begin
      timer_reg <= 32'h0;
    end
  end
endmodule

// File: hw/sal_limiter_top.v
// Stereo output limiter: control registers, thresholds, supply tracking, link and modes
//
// Function
// [RULE1] Fixed threshold code selects 16 V peak at 0 down to 2 V at 31.
// [RULE2] Slope field sets threshold to supply drop ratio 1:1 to 4:1, reset 1.
// [RULE3] Eight-bit supply knee per channel, reset 0x22, compared with supply reading.
// [RULE4] Release rate field gives 3200, 1600, 1200, 800 ms per dB, reset 2.
// [RULE5] Attack rate field gives 120, 60, 30, 20 us per dB, reset 2.
// [RULE6] Link bit set: one shared limiter using left settings; resets to one.
// [RULE7] Tracking set lowers threshold by slope while supply is below knee.
// [RULE8] Mode 0 off, mode 1 always limits, mode 3 limits only below knee.
// [RULE9] Mode 2 mutes the channel while supply is below its knee.
// [RULE10] Left rates, tracking and mode come from left first control register.
// [RULE11] Tracked threshold is fixed minus shortfall over ratio, never above fixed.
// [RULE12] Reserved bits read zero and ignore writes.
`include "sal_regs.vh"

module sal_limiter_top #(
  parameter integer DATA_W    = 24,
  parameter integer THR_SHIFT = 17,
  parameter integer ATT_MAX   = 48,
  parameter [31:0]  ATK0      = `SAL_ATTACK_CYC(`SAL_ATTACK_US_0),
  parameter [31:0]  ATK1      = `SAL_ATTACK_CYC(`SAL_ATTACK_US_1),
  parameter [31:0]  ATK2      = `SAL_ATTACK_CYC(`SAL_ATTACK_US_2),
  parameter [31:0]  ATK3      = `SAL_ATTACK_CYC(`SAL_ATTACK_US_3),
  parameter [31:0]  REL0      = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_0),
  parameter [31:0]  REL1      = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_1),
  parameter [31:0]  REL2      = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_2),
  parameter [31:0]  REL3      = `SAL_RELEASE_CYC(`SAL_RELEASE_MS_3)
) (
  input  wire              clock_i,
  input  wire              reset_n_i,
  input  wire              reg_wr_en_i,
  input  wire              reg_rd_en_i,
  input  wire [7:0]        reg_addr_i,
  input  wire [7:0]        reg_wdata_i,
  output reg  [7:0]        reg_rdata_o,
  input  wire [7:0]        supply_level_i,
  input  wire              sample_valid_i,
  input  wire [DATA_W-1:0] left_sample_i,
  input  wire [DATA_W-1:0] right_sample_i,
  output reg               sample_valid_o,
  output reg  [DATA_W-1:0] left_sample_o,
  output reg  [DATA_W-1:0] right_sample_o,
  output wire              left_mute_o,
  output wire              right_mute_o,
  output wire [5:0]        left_atten_db_o,
  output wire [5:0]        right_atten_db_o
);
  reg  [7:0] left_rates_reg;
  reg  [7:0] left_threshold_slope_reg;
  reg  [7:0] left_supply_knee_reg;
  reg  [7:0] right_rates_mode_reg;
  reg  [7:0] right_threshold_slope_reg;
  reg  [7:0] right_supply_knee_reg;

  // Threshold code to peak level in quarter volts
  function [6:0] thr_quarter_volts;
    input [4:0] code;
    begin
      if (code <= 5'd13)
        thr_quarter_volts = 7'd64 - {code, 1'b0}; // [RULE1]
      else if (code <= 5'd19)
        thr_quarter_volts = 7'd51 - {2'b00, code};
      else
        thr_quarter_volts = 7'd70 - {1'b0, code, 1'b0};
    end
  endfunction

  // Shortfall divided by slope ratio
  function [7:0] slope_scale;
    input [7:0] shortfall;
    input [1:0] slope;
    begin
      case (slope) // [RULE2]
        2'h0:    slope_scale = shortfall;
        2'h1:    slope_scale = shortfall >> 1;
        2'h2:    slope_scale = shortfall / 8'd3;
        default: slope_scale = shortfall >> 2;
      endcase
    end
  endfunction

  // Register writes with reserved bits held at zero
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      left_rates_reg            <= `SAL_RST_LEFT_RATES;
      left_threshold_slope_reg  <= `SAL_RST_THR_SLOPE;
      left_supply_knee_reg      <= `SAL_RST_KNEE; // [RULE3]
      right_rates_mode_reg      <= `SAL_RST_RIGHT_RATES;
      right_threshold_slope_reg <= `SAL_RST_THR_SLOPE;
      right_supply_knee_reg     <= `SAL_RST_KNEE;
    end else if (reg_wr_en_i) begin
      if (reg_addr_i == `SAL_ADDR_LEFT_RATES)
        left_rates_reg <= reg_wdata_i & `SAL_MASK_LEFT_RATES; // [RULE12]
      else if (reg_addr_i == `SAL_ADDR_LEFT_THR_SLOPE)
        left_threshold_slope_reg <= reg_wdata_i & `SAL_MASK_THR_SLOPE; // [RULE12]
      else if (reg_addr_i == `SAL_ADDR_LEFT_KNEE)
        left_supply_knee_reg <= reg_wdata_i;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_RATES)
        right_rates_mode_reg <= reg_wdata_i & `SAL_MASK_RIGHT_RATES;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_THR_SLOPE)
        right_threshold_slope_reg <= reg_wdata_i & `SAL_MASK_THR_SLOPE;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_KNEE)
        right_supply_knee_reg <= reg_wdata_i;
    end
  end

  // Registered read, unmapped reads zero
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_en_i) begin
      if (reg_addr_i == `SAL_ADDR_LEFT_RATES)
        reg_rdata_o <= left_rates_reg;
      else if (reg_addr_i == `SAL_ADDR_LEFT_THR_SLOPE)
        reg_rdata_o <= left_threshold_slope_reg;
      else if (reg_addr_i == `SAL_ADDR_LEFT_KNEE)
        reg_rdata_o <= left_supply_knee_reg;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_RATES)
        reg_rdata_o <= right_rates_mode_reg;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_THR_SLOPE)
        reg_rdata_o <= right_threshold_slope_reg;
      else if (reg_addr_i == `SAL_ADDR_RIGHT_KNEE)
        reg_rdata_o <= right_supply_knee_reg;
      else
        reg_rdata_o <= 8'h00;
    end
  end

  wire shared_limiter_select = right_rates_mode_reg[`SAL_LINK_BIT];

  // Settings in force per channel; linked right follows left
  wire [7:0] l_rates = left_rates_reg; // [RULE10]
  wire [7:0] l_thsl  = left_threshold_slope_reg;
  wire [7:0] l_knee  = left_supply_knee_reg;
  wire [7:0] r_rates = shared_limiter_select ? left_rates_reg : right_rates_mode_reg; // [RULE6]
  wire [7:0] r_thsl  = shared_limiter_select ? left_threshold_slope_reg : right_threshold_slope_reg;
  wire [7:0] r_knee  = shared_limiter_select ? left_supply_knee_reg : right_supply_knee_reg;

  wire [4:0] left_peak_threshold_code  = l_thsl[`SAL_THR_MSB:`SAL_THR_LSB];
  wire [4:0] right_peak_threshold_code = r_thsl[`SAL_THR_MSB:`SAL_THR_LSB];
  wire [1:0] left_limiter_mode         = l_rates[`SAL_MODE_MSB:`SAL_MODE_LSB];
  wire [1:0] right_limiter_mode        = r_rates[`SAL_MODE_MSB:`SAL_MODE_LSB];

  // Low supply means strictly below the knee
  wire l_below = supply_level_i < l_knee; // [RULE3]
  wire r_below = supply_level_i < r_knee;

  // Effective threshold in quarter volts, clamped at zero
  wire [6:0] l_fixed = thr_quarter_volts(left_peak_threshold_code);
  wire [6:0] r_fixed = thr_quarter_volts(right_peak_threshold_code);
  wire [7:0] l_drop  = slope_scale(l_knee - supply_level_i, l_thsl[`SAL_SLOPE_MSB:`SAL_SLOPE_LSB]);
  wire [7:0] r_drop  = slope_scale(r_knee - supply_level_i, r_thsl[`SAL_SLOPE_MSB:`SAL_SLOPE_LSB]);
  wire       l_track = l_rates[`SAL_TRACK_BIT] & l_below; // [RULE7]
  wire       r_track = r_rates[`SAL_TRACK_BIT] & r_below;
  // Tracking lowers the fixed threshold
  reg  [6:0] l_eff;
  reg  [6:0] r_eff;
  always @* begin
    l_eff = l_fixed;
    if (l_track && ({1'b0, l_fixed} > l_drop))
      l_eff = l_fixed - l_drop[6:0]; // [RULE11]
    else if (l_track)
      l_eff = 7'h00; // [RULE11]
    r_eff = r_fixed;
    if (r_track && ({1'b0, r_fixed} > r_drop))
      r_eff = r_fixed - r_drop[6:0]; // [RULE11]
    else if (r_track)
      r_eff = 7'h00; // [RULE11]
  end

  // Threshold amplitude; 16 V reaches full scale and saturates
  wire [DATA_W+6:0] l_thr_wide = {{DATA_W{1'b0}}, l_eff} << THR_SHIFT;
  wire [DATA_W+6:0] r_thr_wide = {{DATA_W{1'b0}}, r_eff} << THR_SHIFT;
  wire              l_thr_sat  = |l_thr_wide[DATA_W+6:DATA_W-1];
  wire              r_thr_sat  = |r_thr_wide[DATA_W+6:DATA_W-1];
  wire [DATA_W-2:0] l_thr_amp  = l_thr_sat ? {(DATA_W-1){1'b1}} : l_thr_wide[DATA_W-2:0]; // [RULE1]
  wire [DATA_W-2:0] r_thr_amp  = r_thr_sat ? {(DATA_W-1){1'b1}} : r_thr_wide[DATA_W-2:0];

  // Limiting enable per mode; mode 2 never limits
  reg        l_active;
  reg        r_active;
  always @* begin
    case (left_limiter_mode) // [RULE8]
      `SAL_MODE_ON:     l_active = 1'b1;
      `SAL_MODE_ON_LOW: l_active = l_below;
      default:          l_active = 1'b0;
    endcase
    case (right_limiter_mode) // [RULE8]
      `SAL_MODE_ON:     r_active = 1'b1;
      `SAL_MODE_ON_LOW: r_active = r_below;
      default:          r_active = 1'b0;
    endcase
  end
  assign left_mute_o  = (left_limiter_mode == `SAL_MODE_MUTE_LOW) && l_below; // [RULE9]
  assign right_mute_o = (right_limiter_mode == `SAL_MODE_MUTE_LOW) && r_below; // [RULE9]

  // Peak magnitudes; linked mode watches the larger of both
  wire [DATA_W-1:0] l_abs = left_sample_i[DATA_W-1] ? -left_sample_i : left_sample_i;
  wire [DATA_W-1:0] r_abs = right_sample_i[DATA_W-1] ? -right_sample_i : right_sample_i;
  wire [DATA_W-2:0] l_mag = l_abs[DATA_W-1] ? {(DATA_W-1){1'b1}} : l_abs[DATA_W-2:0];
  wire [DATA_W-2:0] r_mag = r_abs[DATA_W-1] ? {(DATA_W-1){1'b1}} : r_abs[DATA_W-2:0];
  wire [DATA_W-2:0] l_peak = (shared_limiter_select && (r_mag > l_mag)) ? r_mag : l_mag; // [RULE6]

  reg  [DATA_W-2:0] l_peak_reg;
  reg  [DATA_W-2:0] r_peak_reg;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      l_peak_reg <= {(DATA_W-1){1'b0}};
      r_peak_reg <= {(DATA_W-1){1'b0}};
    end else if (sample_valid_i) begin
      l_peak_reg <= l_peak;
      r_peak_reg <= r_mag;
    end
  end

  wire [15:0] l_gain;
  wire [15:0] r_gain;
  wire [5:0]  l_att;
  wire [5:0]  r_att;

  sal_gain_core #(
    .DATA_W  (DATA_W),
    .ATT_MAX (ATT_MAX),
    .ATK0    (ATK0),
    .ATK1    (ATK1),
    .ATK2    (ATK2),
    .ATK3    (ATK3),
    .REL0    (REL0),
    .REL1    (REL1),
    .REL2    (REL2),
    .REL3    (REL3)
  ) u_left_core (
    .clock_i         (clock_i),
    .reset_n_i       (reset_n_i),
    .active_i        (l_active),
    .peak_i          (l_peak_reg),
    .threshold_i     (l_thr_amp),
    .attack_code_i   (l_rates[`SAL_ATTACK_MSB:`SAL_ATTACK_LSB]),
    .recovery_code_i (l_rates[`SAL_RECOVERY_MSB:`SAL_RECOVERY_LSB]),
    .gain_o          (l_gain),
    .atten_db_o      (l_att)
  );

  sal_gain_core #(
    .DATA_W  (DATA_W),
    .ATT_MAX (ATT_MAX),
    .ATK0    (ATK0),
    .ATK1    (ATK1),
    .ATK2    (ATK2),
    .ATK3    (ATK3),
    .REL0    (REL0),
    .REL1    (REL1),
    .REL2    (REL2),
    .REL3    (REL3)
  ) u_right_core (
    .clock_i         (clock_i),
    .reset_n_i       (reset_n_i),
    .active_i        (r_active & ~shared_limiter_select),
    .peak_i          (r_peak_reg),
    .threshold_i     (r_thr_amp),
    .attack_code_i   (r_rates[`SAL_ATTACK_MSB:`SAL_ATTACK_LSB]),
    .recovery_code_i (r_rates[`SAL_RECOVERY_MSB:`SAL_RECOVERY_LSB]),
    .gain_o          (r_gain),
    .atten_db_o      (r_att)
  );

  // Linked: right channel uses the shared gain
  // Unity is 0x8000 in Q15
  reg  [15:0] l_use;
  reg  [15:0] r_use;
  always @* begin
    l_use = 16'h8000;
    if (l_active)
      l_use = l_gain;
    r_use = 16'h8000;
    if (shared_limiter_select)
      r_use = l_use; // [RULE6]
    else if (r_active)
      r_use = r_gain;
  end
  assign left_atten_db_o  = l_att;
  assign right_atten_db_o = shared_limiter_select ? l_att : r_att;

  wire signed [DATA_W+16:0] l_prod = $signed(left_sample_i) * $signed({1'b0, l_use});
  wire signed [DATA_W+16:0] r_prod = $signed(right_sample_i) * $signed({1'b0, r_use});

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      sample_valid_o <= 1'b0;
      left_sample_o  <= {DATA_W{1'b0}};
      right_sample_o <= {DATA_W{1'b0}};
    end else begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        left_sample_o  <= left_mute_o ? {DATA_W{1'b0}} : l_prod[DATA_W+14:15]; // [RULE9]
        right_sample_o <= right_mute_o ? {DATA_W{1'b0}} : r_prod[DATA_W+14:15];
      end
    end
  end
endmodule

// File: verification/sal_limiter_props.sv
// Port-level property checker for the stereo limiter top
module sal_limiter_props #(
  parameter integer DATA_W = 24
) (
  input wire logic              clock_i,
  input wire logic              reset_n_i,
  input wire logic              reg_wr_en_i,
  input wire logic              reg_rd_en_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic [7:0]        supply_level_i,
  input wire logic              sample_valid_i,
  input wire logic [DATA_W-1:0] left_sample_i,
  input wire logic [DATA_W-1:0] right_sample_i,
  input wire logic              sample_valid_o,
  input wire logic [DATA_W-1:0] left_sample_o,
  input wire logic [DATA_W-1:0] right_sample_o,
  input wire logic              left_mute_o,
  input wire logic              right_mute_o,
  input wire logic [5:0]        left_atten_db_o,
  input wire logic [5:0]        right_atten_db_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // Shadow copies of the mode and knee registers
  logic [7:0] l_rates_reg;
  logic [7:0] l_knee_reg;
  logic [7:0] r_rates_reg;
  logic [7:0] r_knee_reg;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      l_rates_reg <= 8'ha0;
      l_knee_reg  <= 8'h22;
      r_rates_reg <= 8'ha8;
      r_knee_reg  <= 8'h22;
    end else if (reg_wr_en_i) begin
      case (reg_addr_i)
        8'h0e: l_rates_reg <= reg_wdata_i & 8'hf7;
        8'h10: l_knee_reg <= reg_wdata_i;
        8'h11: r_rates_reg <= reg_wdata_i;
        8'h13: r_knee_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end
  wire       l_low  = supply_level_i < l_knee_reg;
  wire       r_low  = supply_level_i < r_knee_reg;
  wire [1:0] l_mode = l_rates_reg[1:0];
  wire [1:0] r_mode = r_rates_reg[1:0];
  wire       l_idle = (l_mode == 2'h0) || (l_mode == 2'h2) || (l_mode == 2'h3 && !l_low);
  wire       r_mute_exp = r_rates_reg[3] ? (l_mode == 2'h2 && l_low) : (r_mode == 2'h2 && r_low);
  wire       unmapped = (reg_addr_i < 8'h0e) || (reg_addr_i > 8'h13);

  sequence s_left_idle;
    l_idle [*3];
  endsequence
  sequence s_left_passing;
    (l_idle && left_atten_db_o == 6'h0) [*3] ##0 (sample_valid_i && !left_mute_o);
  endsequence

  a_valid_follows: assert property (sample_valid_i |=> sample_valid_o)
    else $error("output strobe missing after input strobe");
  a_rdata_holds: assert property (!reg_rd_en_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_reads_zero: assert property (reg_rd_en_i && unmapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_bits_zero: assert property (reg_rd_en_i && reg_addr_i inside {8'h0e, 8'h0f, 8'h12}
    |=> (reg_rdata_o & (($past(reg_addr_i) == 8'h0e) ? 8'h08 : 8'h04)) == 8'h00)
    else $error("reserved bit read back set");
  a_left_mute_level: assert property (left_mute_o == (l_mode == 2'h2 && l_low))
    else $error("left mute disagrees with mode and knee");
  a_right_mute_link: assert property (right_mute_o == r_mute_exp)
    else $error("right mute disagrees with link, mode and knee");
  a_idle_no_atten: assert property (s_left_idle |-> left_atten_db_o == 6'h0)
    else $error("attenuation while limiter inactive");
  a_muted_sample_zero: assert property (sample_valid_i && left_mute_o |=> left_sample_o == '0)
    else $error("muted left sample not zero");
  a_unity_pass: assert property (s_left_passing |=> left_sample_o == $past(left_sample_i))
    else $error("inactive limiter altered the sample");
  a_atten_one_step: assert property (left_atten_db_o <= $past(left_atten_db_o) + 6'h1)
    else $error("attenuation rose by more than one step");
endmodule

// File: verification/tb_sal_limiter_top.sv
// Self-checking bench for the stereo limiter top
module tb_sal_limiter_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        reg_wr_en_i = 1'b0;
  logic        reg_rd_en_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  supply_level_i = 8'h80;
  logic        sample_valid_i = 1'b0;
  logic [23:0] left_sample_i = 24'h000000;
  logic [23:0] right_sample_i = 24'h000000;
  wire  [7:0]  reg_rdata_o;
  wire         sample_valid_o;
  wire  [23:0] left_sample_o;
  wire  [23:0] right_sample_o;
  wire         left_mute_o;
  wire         right_mute_o;
  wire  [5:0]  left_atten_db_o;
  wire  [5:0]  right_atten_db_o;
  integer      n_fail = 0;
  integer      checked = 0;

  always #2 clock_i = ~clock_i;

  // Short attack and release counts keep the run brief
  sal_limiter_top #(.ATK0(8), .ATK3(2), .REL3(10))
    sal_limiter_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_wr_en_i(reg_wr_en_i),
    .reg_rd_en_i(reg_rd_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .supply_level_i(supply_level_i), .sample_valid_i(sample_valid_i), .left_sample_i(left_sample_i),
    .right_sample_i(right_sample_i), .sample_valid_o(sample_valid_o), .left_sample_o(left_sample_o),
    .right_sample_o(right_sample_o), .left_mute_o(left_mute_o), .right_mute_o(right_mute_o),
    .left_atten_db_o(left_atten_db_o), .right_atten_db_o(right_atten_db_o));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_wr_en_i = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge clock_i);
    reg_wr_en_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    reg_rd_en_i = 1'b1;
    reg_addr_i  = a;
    @(negedge clock_i);
    reg_rd_en_i = 1'b0;
    chk($sformatf("register %h", a), {16'h0000, reg_rdata_o}, {16'h0000, exp});
  endtask

  // Clears attenuation, configures the left limiter, then streams a constant sample
  task automatic probe(input logic [7:0] rates, input logic [7:0] thr, input logic [7:0] knee,
                       input logic [7:0] sup, input logic [23:0] s, input logic lim, output logic [5:0] att);
    wr(8'h0e, 8'h30);
    wr(8'h0f, thr);
    wr(8'h10, knee);
    supply_level_i = sup;
    wr(8'h0e, rates);
    sample_valid_i = 1'b1;
    left_sample_i  = s;
    right_sample_i = s;
    repeat (40) @(negedge clock_i);
    sample_valid_i = 1'b0;
    att = left_atten_db_o;
    chk("left limiting", {23'h0, left_atten_db_o != 6'h00}, {23'h0, lim});
    chk("right limiting", {23'h0, right_atten_db_o != 6'h00}, {23'h0, lim});
    chk("left reduced", {23'h0, left_sample_o < s - (s >> 3)}, {23'h0, lim});
  endtask

  task automatic t_regs;
    logic [7:0] adr [8] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h0d, 8'h14};
    logic [7:0] rst [8] = '{8'ha0, 8'h51, 8'h22, 8'ha8, 8'h51, 8'h22, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk(adr[i], rst[i]);
    wr(8'h0e, 8'hff);
    rd_chk(8'h0e, 8'hf7);
    wr(8'h0f, 8'hff);
    rd_chk(8'h0f, 8'hfb);
    wr(8'h12, 8'hff);
    rd_chk(8'h12, 8'hfb);
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, {i[1:0], i[1:0], 2'h2, i[1:0]});
      rd_chk(8'h11, {i[1:0], i[1:0], 2'h2, i[1:0]});
    end
    $display("test registers done");
  endtask

  task automatic t_mute;
    wr(8'h0e, 8'h32);
    wr(8'h10, 8'h40);
    wr(8'h11, 8'ha2);
    wr(8'h13, 8'h22);
    supply_level_i = 8'h30;
    sample_valid_i = 1'b1;
    left_sample_i  = 24'h123456;
    right_sample_i = 24'h123456;
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    @(negedge clock_i);
    chk("left mute", {23'h0, left_mute_o}, 24'h1);
    chk("right mute", {23'h0, right_mute_o}, 24'h0);
    chk("left muted sample", left_sample_o, 24'h000000);
    chk("right sample", right_sample_o, 24'h123456);
    supply_level_i = 8'h40;
    @(negedge clock_i);
    chk("left mute at knee", {23'h0, left_mute_o}, 24'h0);
    supply_level_i = 8'h30;
    wr(8'h11, 8'haa);
    chk("linked right mute", {23'h0, right_mute_o}, 24'h1);
    $display("test mute done");
  endtask

  task automatic t_limit;
    logic [5:0] a0;
    logic [5:0] a3;
    probe(8'h31, 8'hf9, 8'h22, 8'h80, 24'h7fffff, 1'b1, a3);
    probe(8'h01, 8'hf9, 8'h22, 8'h80, 24'h7fffff, 1'b1, a0);
    chk("attack faster", {23'h0, a3 > a0}, 24'h1);
    probe(8'hf1, 8'hf9, 8'h22, 8'h80, 24'h7fffff, 1'b1, a3);
    @(negedge clock_i);
    sample_valid_i = 1'b1;
    left_sample_i  = 24'h000000;
    right_sample_i = 24'h000000;
    repeat (30) @(negedge clock_i);
    chk("release pace", {23'h0, left_atten_db_o < a3 && left_atten_db_o >= a3 - 6'h3}, 24'h1);
    sample_valid_i = 1'b0;
    probe(8'h31, 8'h01, 8'h22, 8'h80, 24'h7fffff, 1'b0, a0);
    probe(8'h33, 8'hf9, 8'h22, 8'h80, 24'h7fffff, 1'b0, a0);
    probe(8'h35, 8'h00, 8'h40, 8'h00, 24'h500000, 1'b1, a0);
    probe(8'h35, 8'h03, 8'h40, 8'h00, 24'h500000, 1'b0, a0);
    probe(8'h35, 8'h00, 8'h40, 8'h40, 24'h500000, 1'b0, a0);
    probe(8'h31, 8'h00, 8'h40, 8'h00, 24'h500000, 1'b0, a0);
    probe(8'h33, 8'hf9, 8'h22, 8'h10, 24'h7fffff, 1'b1, a0);
    wr(8'h0e, 8'h30);
    @(negedge clock_i);
    chk("atten after off", {18'h0, left_atten_db_o}, 24'h0);
    $display("test limiter done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_regs;
    t_mute;
    t_limit;
    tally_and_finish;
  end

  initial begin
    #80000;
    n_fail++;
    tally_and_finish;
  end
endmodule

bind sal_limiter_top sal_limiter_props #(.DATA_W(DATA_W)) sal_limiter_props_i (.clock_i(clock_i),
  .reset_n_i(reset_n_i), .reg_wr_en_i(reg_wr_en_i), .reg_rd_en_i(reg_rd_en_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .supply_level_i(supply_level_i),
  .sample_valid_i(sample_valid_i), .left_sample_i(left_sample_i), .right_sample_i(right_sample_i),
  .sample_valid_o(sample_valid_o), .left_sample_o(left_sample_o), .right_sample_o(right_sample_o),
  .left_mute_o(left_mute_o), .right_mute_o(right_mute_o), .left_atten_db_o(left_atten_db_o),
  .right_atten_db_o(right_atten_db_o));
